// ---- hdl/instr_decoder.sv ----
// instruction word decoder with cycle sequencing and debug port steering
// Overview of operation
// - each word is 24 bits; top 8 bits are opcode, rest operands.
// - exactly three opcodes take two words, 48 bits in total.
// - second word has zero top byte; executed alone it is a no-op.
// - plain single-word instructions finish in one cycle.
// - true condition or changed program counter adds one no-op cycle.
// - jumps, indirect call/goto, table access, returns take two or three cycles.
// - taken skip costs two cycles over one word, three over two words.
// - double-word moves and all two-word instructions take two cycles.
// - file operations carry address and destination of same file or register zero.
// - three-register operations carry base, source and destination with modes.
// - bit operations select the bit by literal or by base register contents.
// - literal arithmetic carries base, literal, destination only when different.
// - debug traffic is accepted on the one selected clock/data pair.
// - debug enabled reserves lowest 80 data bytes and two pins.
// - pair select 11 pair one, 10 pair two, 01 pair three, 00 reserved.
`timescale 1ns/100ps
module instr_decoder (
   input  wire logic        sys_clk,            // core clock, 200 MHz
   input  wire logic        rstn,               // async reset, active low
   input  wire logic [23:0] fetch_word,         // program word from fetch
   input  wire logic        fetch_valid,        // fetch_word is valid
   output logic             fetch_ready,        // decoder takes word this cycle
   input  wire logic        cond_true,          // condition test result
   input  wire logic        skip_taken,         // skip condition met
   output logic             instr_done,         // pulse: instruction retired
   output logic [7:0]       opcode,             // opcode of last instruction
   output decode_pkg::class_type op_class,      // operand class
   output logic [1:0]       cycle_count,        // cycles it took
   output logic             is_two_word,        // it used an extension word
   output logic [15:0]      extension,          // extension word operand bits
   output logic [3:0]       base_operand_reg,   // base register
   output logic [3:0]       source_operand_reg, // source register
   output logic [2:0]       source_mode,        // source address mode
   output logic [3:0]       dest_operand_reg,   // destination register
   output logic [2:0]       dest_mode,          // destination address mode
   output logic [12:0]      file_addr,          // file register address
   output logic             dest_is_reg_zero,   // file result to register zero
   output logic [3:0]       bit_select,         // selected bit number
   output logic             bit_from_base,      // bit comes from base contents
   output logic [9:0]       literal,            // literal operand
   output logic             dest_present,       // separate destination encoded
   input  wire logic        debug_enable,       // debug feature enabled
   input  wire logic [1:0]  debug_pair_select,  // pair select field
   input  wire logic [2:0]  debug_clock_pin,    // clock pins of three pairs
   input  wire logic [2:0]  debug_data_pin_in,  // data pins of three pairs
   output logic [2:0]       debug_data_pin_out, // data drive per pair
   output logic [2:0]       debug_data_pin_oe_n,// data enable per pair, low drives
   input  wire logic        debug_data_out,     // data the debugger sends out
   input  wire logic        debug_data_drive,   // debugger drives data now
   output logic             debug_clock,        // synchronised selected clock
   output logic             debug_data,         // synchronised selected data
   output logic             debug_pair_valid,   // debug enabled and a legal pair is selected
   input  wire logic [15:0] data_addr,          // application data address
   output logic             data_reserved,      // address held for debugger
   output logic             pins_reserved       // two pins held for debugger
);
   typedef enum logic [1:0] {
      ST_FIRST  = 2'b00,
      ST_SECOND = 2'b01,
      ST_STALL  = 2'b10
   } seq_state_type;

   function automatic logic two_word_op(input logic [7:0] op);
      two_word_op = (op == decode_pkg::OP_CALL2) || (op == decode_pkg::OP_GOTO2)
                 || (op == decode_pkg::OP_DO2);
   endfunction

   function automatic decode_pkg::class_type classify(input logic [7:0] op);
      case (op)
         decode_pkg::OP_NOP2:      classify = decode_pkg::CLS_NOP;
         decode_pkg::OP_FILE:      classify = decode_pkg::CLS_FILE;
         decode_pkg::OP_REG3:      classify = decode_pkg::CLS_REG3;
         decode_pkg::OP_BIT_LIT,
         decode_pkg::OP_BIT_IND:   classify = decode_pkg::CLS_BIT;
         decode_pkg::OP_LIT_ARITH: classify = decode_pkg::CLS_LIT;
         decode_pkg::OP_CALL2, decode_pkg::OP_GOTO2, decode_pkg::OP_DO2,
         decode_pkg::OP_JUMP, decode_pkg::OP_JUMP_COND, decode_pkg::OP_IND_CALL,
         decode_pkg::OP_IND_GOTO, decode_pkg::OP_RETURN, decode_pkg::OP_INT_RET,
         decode_pkg::OP_SKIP:      classify = decode_pkg::CLS_CONTROL;
         default:                  classify = decode_pkg::CLS_OTHER;
      endcase
   endfunction

   // single-word cycle cost; skip is handled separately
   function automatic logic [1:0] base_cycles(input logic [7:0] op, input logic cond);
      case (op)
         decode_pkg::OP_JUMP, decode_pkg::OP_IND_CALL, decode_pkg::OP_IND_GOTO,
         decode_pkg::OP_TBL_RD, decode_pkg::OP_TBL_WR:
            base_cycles = decode_pkg::CYC_TWO;
         decode_pkg::OP_RETURN, decode_pkg::OP_INT_RET:
            base_cycles = decode_pkg::CYC_THREE;
         decode_pkg::OP_MOV_D:
            base_cycles = decode_pkg::CYC_TWO;
         decode_pkg::OP_JUMP_COND:
            base_cycles = cond ? decode_pkg::CYC_TWO : decode_pkg::CYC_ONE;
         default:
            base_cycles = decode_pkg::CYC_ONE;
      endcase
   endfunction

   seq_state_type state;
   logic [23:0]   first_word;
   logic [1:0]    stall_left;
   logic [1:0]    used_cycles;
   logic          skip_pending;
   logic [1:0]    skip_cycles;
   logic          take;
   logic [7:0]    in_op;
   logic          in_two;

   assign in_op       = fetch_word[decode_pkg::OPCODE_LSB +: decode_pkg::OPCODE_WIDTH];
   assign in_two      = two_word_op(in_op);
   assign fetch_ready = (state != ST_STALL);
   assign take        = fetch_valid && fetch_ready;

   // sequencer: one fetch accepted per instruction cycle when not stalled
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         state        <= ST_FIRST;
         first_word   <= '0;
         stall_left   <= 2'h0;
         used_cycles  <= 2'h0;
         skip_pending <= 1'b0;
         skip_cycles  <= 2'h0;
      end else begin
         case (state)
            ST_FIRST: begin
               if (take) begin
                  if (skip_pending) begin
                     // skipped word is discarded; a two-word one costs one more
                     skip_pending <= 1'b0;
                     if (in_two) begin
                        skip_cycles <= decode_pkg::CYC_THREE;
                        state       <= ST_SECOND;
                     end
                  end else if (in_two) begin
                     first_word <= fetch_word;
                     state      <= ST_SECOND;
                  end else begin
                     first_word <= fetch_word;
                     if (in_op == decode_pkg::OP_SKIP && skip_taken) begin
                        skip_pending <= 1'b1;
                        skip_cycles  <= decode_pkg::CYC_TWO;
                     end
                     if (base_cycles(in_op, cond_true) != decode_pkg::CYC_ONE) begin
                        stall_left  <= base_cycles(in_op, cond_true) - 2'h1;
                        used_cycles <= base_cycles(in_op, cond_true);
                        state       <= ST_STALL;
                     end
                  end
               end
            end
            ST_SECOND: begin
               if (take) begin
                  state <= ST_FIRST;
               end
            end
            ST_STALL: begin
               stall_left <= stall_left - 2'h1;
               if (stall_left == 2'h1) begin
                  state <= ST_FIRST;
               end
            end
            default: state <= ST_FIRST;
         endcase
      end
   end

   logic       next_done;
   logic [1:0] next_cycles;
   always_comb begin
      next_done   = 1'b0;
      next_cycles = decode_pkg::CYC_ONE;
      case (state)
         ST_FIRST: begin
            if (take && !skip_pending && !in_two
                && base_cycles(in_op, cond_true) == decode_pkg::CYC_ONE) begin
               next_done = 1'b1;
               if (in_op == decode_pkg::OP_SKIP && skip_taken) begin
                  next_done = 1'b0;
               end
            end else if (take && skip_pending && !in_two) begin
               next_done   = 1'b1;
               next_cycles = skip_cycles;
            end
         end
         ST_SECOND: begin
            if (take) begin
               next_done   = 1'b1;
               next_cycles = (first_word[23:16] == decode_pkg::OP_SKIP) ?
                             decode_pkg::CYC_THREE : decode_pkg::CYC_TWO;
            end
         end
         ST_STALL: begin
            if (stall_left == 2'h1) begin
               next_done   = 1'b1;
               next_cycles = used_cycles;
            end
         end
         default: next_done = 1'b0;
      endcase
   end

   logic [23:0] dec_word;
   assign dec_word = (state == ST_FIRST) ? fetch_word : first_word;

   // result registers
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         instr_done  <= 1'b0;
         cycle_count <= 2'h0;
         opcode      <= 8'h00;
         op_class    <= decode_pkg::CLS_NOP;
         is_two_word <= 1'b0;
         extension   <= 16'h0000;
      end else begin
         instr_done <= next_done;
         if (next_done) begin
            cycle_count <= next_cycles;
            opcode      <= dec_word[decode_pkg::OPCODE_LSB +: decode_pkg::OPCODE_WIDTH];
            // a lone extension word has zero top byte, so decodes as no-op
            op_class    <= classify(dec_word[decode_pkg::OPCODE_LSB +:
                                            decode_pkg::OPCODE_WIDTH]);
            is_two_word <= (state == ST_SECOND);
            extension   <= (state == ST_SECOND) ?
                           fetch_word[decode_pkg::OPERAND_WIDTH-1:0] : 16'h0000;
         end
      end
   end

   // operand field extraction
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         base_operand_reg   <= 4'h0;
         source_operand_reg <= 4'h0;
         source_mode        <= 3'h0;
         dest_operand_reg   <= 4'h0;
         dest_mode          <= 3'h0;
         file_addr          <= 13'h0000;
         dest_is_reg_zero   <= 1'b0;
         bit_select         <= 4'h0;
         bit_from_base      <= 1'b0;
         literal            <= 10'h000;
         dest_present       <= 1'b0;
      end else if (next_done) begin
         base_operand_reg   <= dec_word[decode_pkg::BASE_LSB +: decode_pkg::REG_WIDTH];
         source_operand_reg <= dec_word[decode_pkg::SRC_LSB +: decode_pkg::REG_WIDTH];
         source_mode        <= dec_word[decode_pkg::MODE_S_LSB +: decode_pkg::MODE_WIDTH];
         dest_operand_reg   <= dec_word[decode_pkg::DEST_LSB +: decode_pkg::REG_WIDTH];
         dest_mode          <= dec_word[decode_pkg::MODE_D_LSB+4 +: decode_pkg::MODE_WIDTH];
         file_addr          <= dec_word[decode_pkg::FILE_WIDTH-1:0];
         dest_is_reg_zero   <= !dec_word[decode_pkg::FILE_DEST_BIT];
         bit_select         <= dec_word[decode_pkg::BIT_LSB +: decode_pkg::REG_WIDTH];
         bit_from_base      <= (dec_word[23:16] == decode_pkg::OP_BIT_IND);
         literal            <= dec_word[decode_pkg::LIT_LSB +: decode_pkg::LIT_WIDTH];
         dest_present       <= !dec_word[decode_pkg::LIT_SAME_BIT];
      end
   end

   // debug pins: synchronise all pairs, then pick the selected one
   logic [2:0] clk_meta, clk_sync, dat_meta, dat_sync;
   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         clk_meta <= 3'h0;
         clk_sync <= 3'h0;
         dat_meta <= 3'h0;
         dat_sync <= 3'h0;
      end else begin
         clk_meta <= debug_clock_pin;
         clk_sync <= clk_meta;
         dat_meta <= debug_data_pin_in;
         dat_sync <= dat_meta;
      end
   end

   logic [2:0] pair_onehot;
   always_comb begin
      case (debug_pair_select)
         decode_pkg::PAIR_ONE:   pair_onehot = 3'h1;
         decode_pkg::PAIR_TWO:   pair_onehot = 3'h2;
         decode_pkg::PAIR_THREE: pair_onehot = 3'h4;
         default:                pair_onehot = 3'h0; // reserved: no pair
      endcase
   end

   logic [2:0] pair_active;
   assign pair_active = pair_onehot & {3{debug_enable}};
   genvar g;
   generate
      for (g = 0; g < decode_pkg::PAIR_COUNT; g++) begin : g_pair
         always_ff @(posedge sys_clk or negedge rstn) begin
            if (!rstn) begin
               debug_data_pin_out[g]  <= 1'b0;
               debug_data_pin_oe_n[g] <= 1'b1;
            end else begin
               debug_data_pin_out[g]  <= debug_data_out;
               debug_data_pin_oe_n[g] <= !(pair_active[g] && debug_data_drive);
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         debug_clock      <= 1'b0;
         debug_data       <= 1'b0;
         debug_pair_valid <= 1'b0;
         data_reserved    <= 1'b0;
         pins_reserved    <= 1'b0;
      end else begin
         debug_clock      <= |(clk_sync & pair_active);
         debug_data       <= |(dat_sync & pair_active);
         debug_pair_valid <= |pair_active;
         data_reserved    <= debug_enable &&
                             (data_addr < 16'(decode_pkg::DEBUG_RAM_BYTES));
         pins_reserved    <= debug_enable;
      end
   end

   a_two_word_cost: assert property (@(posedge sys_clk) disable iff (!rstn)
      instr_done && is_two_word |-> cycle_count != decode_pkg::CYC_ONE)
      else $error("two-word instruction retired in one cycle");
   a_reserved_ram: assert property (@(posedge sys_clk) disable iff (!rstn)
      debug_enable && data_addr == 16'h004F |=> data_reserved) else $error("low ram not held");
   a_reserved_pair: assert property (@(posedge sys_clk) disable iff (!rstn)
      debug_pair_select == decode_pkg::PAIR_RESERVED |=> !debug_pair_valid)
      else $error("reserved pair select accepted");
   a_pins_released: assert property (@(posedge sys_clk) disable iff (!rstn)
      !debug_enable |=> debug_data_pin_oe_n == 3'h7) else $error("pins driven while off");
   sequence s_two_stalls;
      !fetch_ready ##1 !fetch_ready ##1 instr_done && cycle_count == decode_pkg::CYC_THREE;
   endsequence
   a_return_stall: assert property (@(posedge sys_clk) disable iff (!rstn)
      take && !skip_pending && state == ST_FIRST && in_op == decode_pkg::OP_RETURN
      |=> s_two_stalls) else $error("return did not stall two cycles");
   a_lone_extension: assert property (@(posedge sys_clk) disable iff (!rstn)
      instr_done && opcode == decode_pkg::OP_NOP2 |-> op_class == decode_pkg::CLS_NOP)
      else $error("zero top byte not decoded as no-op");
endmodule

// ---- hdl/decode_pkg.sv ----
// constants for the instruction word decoder and debug pin steering
package decode_pkg;
   localparam int WORD_WIDTH    = 24;
   localparam int OPCODE_WIDTH  = 8;
   localparam int OPCODE_LSB    = 16;
   localparam int OPERAND_WIDTH = 16;
   // operand field positions
   localparam int BASE_LSB      = 11;
   localparam int MODE_D_LSB    = 7;
   localparam int DEST_LSB      = 7;
   localparam int MODE_S_LSB    = 4;
   localparam int SRC_LSB       = 0;
   localparam int REG_WIDTH     = 4;
   localparam int MODE_WIDTH    = 3;
   localparam int BIT_LSB       = 12;
   localparam int FILE_WIDTH    = 13;
   localparam int FILE_DEST_BIT = 13;
   localparam int LIT_LSB       = 4;
   localparam int LIT_WIDTH     = 10;
   localparam int LIT_SAME_BIT  = 14;
   // opcode top bytes (coined encoding for the opcode classes)
   localparam logic [7:0] OP_NOP2      = 8'h00;
   localparam logic [7:0] OP_CALL2     = 8'h02;
   localparam logic [7:0] OP_GOTO2     = 8'h04;
   localparam logic [7:0] OP_DO2       = 8'h08;
   localparam logic [7:0] OP_JUMP      = 8'h37;
   localparam logic [7:0] OP_JUMP_COND = 8'h30;
   localparam logic [7:0] OP_IND_CALL  = 8'h01;
   localparam logic [7:0] OP_IND_GOTO  = 8'h05;
   localparam logic [7:0] OP_RETURN    = 8'h06;
   localparam logic [7:0] OP_INT_RET   = 8'h07;
   localparam logic [7:0] OP_TBL_RD    = 8'hBA;
   localparam logic [7:0] OP_TBL_WR    = 8'hBB;
   localparam logic [7:0] OP_SKIP      = 8'hA6;
   localparam logic [7:0] OP_MOV_D     = 8'hBE;
   localparam logic [7:0] OP_REG3      = 8'h40;
   localparam logic [7:0] OP_FILE      = 8'hB4;
   localparam logic [7:0] OP_BIT_LIT   = 8'hA8;
   localparam logic [7:0] OP_BIT_IND   = 8'hAD;
   localparam logic [7:0] OP_LIT_ARITH = 8'hB0;
   // cycle counts in instruction cycles
   localparam logic [1:0] CYC_ONE   = 2'h1;
   localparam logic [1:0] CYC_TWO   = 2'h2;
   localparam logic [1:0] CYC_THREE = 2'h3;
   // debug pair select encodings
   localparam logic [1:0] PAIR_ONE      = 2'h3;
   localparam logic [1:0] PAIR_TWO      = 2'h2;
   localparam logic [1:0] PAIR_THREE    = 2'h1;
   localparam logic [1:0] PAIR_RESERVED = 2'h0;
   localparam int DEBUG_RAM_BYTES = 80;
   localparam int DATA_ADDR_WIDTH = 16;
   localparam int PAIR_COUNT      = 3;

   typedef enum logic [2:0] {
      CLS_NOP      = 3'h0,
      CLS_FILE     = 3'h1,
      CLS_REG3     = 3'h2,
      CLS_BIT      = 3'h3,
      CLS_LIT      = 3'h4,
      CLS_CONTROL  = 3'h5,
      CLS_OTHER    = 3'h6
   } class_type;

   typedef enum logic [1:0] {
      ST_FIRST  = 2'h0,
      ST_SECOND = 2'h1,
      ST_STALL  = 2'h2
   } state_type;
endpackage

// ---- test/debug_tool.sv ----
// behavioural debug tool that clocks data into one serial pin pair per frame
`timescale 1ns/100ps
module debug_tool (
   input  wire logic  sys_clk,              // pacing reference
   output logic [2:0] clk_drive = 3'h0,     // clock pin driven, per pair
   output logic [2:0] clk_level = 3'h0,     // clock pin level, per pair
   output logic [2:0] dat_drive = 3'h0,     // data pin driven, per pair
   output logic [2:0] dat_level = 3'h0,     // data pin level, per pair
   output logic       settled   = 1'b0      // last cycle of a level hold
);
   // eight cycles per level, well past the three-cycle pin synchroniser
   task automatic hold;
      for (int c = 0; c < 8; c++) begin
         settled = (c == 7);
         @(posedge sys_clk);
         #1;
      end
   endtask
   // only the chosen pair is driven; the rest stay released
   task automatic frame(input int pair, input logic [7:0] bits);
      clk_drive = 3'(1 << pair);
      dat_drive = 3'(1 << pair);
      for (int b = 7; b >= 0; b--) begin
         clk_level = 3'h0;
         dat_level = {3{bits[b]}};
         hold();
         clk_level = 3'h7;
         hold();
      end
      clk_level = 3'h0;
      hold();
      clk_drive = 3'h0;
      dat_drive = 3'h0;
      settled   = 1'b0;
   endtask
endmodule

// ---- test/tb_top.sv ----
// self-checking bench for the instruction decoder and debug pin steering
`timescale 1ns/100ps
module tb_top;
   typedef struct {
      logic [23:0] w0, w1, w2;
      int          n;
      logic        cond, skip;
      int          cyc;
   } row_type;
   logic        sys_clk = 1'b0, rstn = 1'b0, fetch_valid = 1'b0, cond_true = 1'b0;
   logic [23:0] fetch_word = 24'h0;
   logic        skip_taken = 1'b0, fetch_ready, instr_done, is_two_word, dest_is_reg_zero;
   logic [7:0]  opcode;
   decode_pkg::class_type op_class;
   logic [1:0]  cycle_count, debug_pair_select = 2'h0;
   logic [15:0] extension, data_addr = 16'h0;
   logic [3:0]  base_operand_reg, source_operand_reg, dest_operand_reg, bit_select;
   logic [2:0]  source_mode, dest_mode, debug_clock_pin, debug_data_pin_in, en_exp;
   logic [2:0]  debug_data_pin_out, debug_data_pin_oe_n, clk_drive, clk_level, dat_drive, dat_level;
   logic [12:0] file_addr;
   logic [9:0]  literal;
   logic        bit_from_base, dest_present, debug_enable = 1'b0, debug_data_out = 1'b0;
   logic        debug_data_drive = 1'b0, debug_clock, debug_data, debug_pair_valid;
   logic        data_reserved, pins_reserved, tool_settled, frame_on = 1'b0;
   int          frame_pair = 0, fails = 0, check_count = 0, stalls = 0, dones = 0, cycles = 0;
   logic [15:0] addrs [4] = '{16'h0000, 16'h004F, 16'h0050, 16'hFFFF};
   row_type     rows [26] = '{
      '{24'hB42ABC, 0, 0, 1, 0, 0, 1}, '{24'hB40005, 0, 0, 1, 0, 0, 1},
      '{24'h407A5C, 0, 0, 1, 0, 0, 1}, '{24'hA8F123, 0, 0, 1, 0, 0, 1},
      '{24'hAD5801, 0, 0, 1, 0, 0, 1}, '{24'hB04FF0, 0, 0, 1, 0, 0, 1},
      '{24'hB03010, 0, 0, 1, 0, 0, 1}, '{24'h300000, 0, 0, 1, 0, 0, 1},
      '{24'h300000, 0, 0, 1, 1, 0, 2}, '{24'h370000, 0, 0, 1, 0, 0, 2},
      '{24'h010003, 0, 0, 1, 0, 0, 0}, '{24'h050003, 0, 0, 1, 0, 0, 0},
      '{24'hBA0000, 0, 0, 1, 0, 0, 0}, '{24'hBB0000, 0, 0, 1, 0, 0, 0},
      '{24'h060000, 0, 0, 1, 0, 0, 3}, '{24'h070000, 0, 0, 1, 0, 0, 3},
      '{24'hBE0000, 0, 0, 1, 0, 0, 2}, '{24'h021234, 24'h00BEEF, 0, 2, 0, 0, 2},
      '{24'h044321, 24'h000001, 0, 2, 0, 0, 2}, '{24'h08ABCD, 24'h00FFFF, 0, 2, 0, 0, 2},
      '{24'h000000, 0, 0, 1, 0, 0, 1}, '{24'h001234, 0, 0, 1, 0, 0, 1},
      '{24'hA60000, 0, 0, 1, 0, 0, 1}, '{24'hA60000, 24'hB40001, 0, 2, 0, 1, 2},
      '{24'hA60000, 24'h04ABCD, 24'h005678, 3, 0, 1, 3},
      '{24'h021234, 24'h00BEEF, 0, 2, 0, 0, 2}};

   instr_decoder u_dut (
      .sys_clk, .rstn, .fetch_word, .fetch_valid, .fetch_ready, .cond_true, .skip_taken,
      .instr_done, .opcode, .op_class, .cycle_count, .is_two_word, .extension,
      .base_operand_reg, .source_operand_reg, .source_mode, .dest_operand_reg, .dest_mode,
      .file_addr, .dest_is_reg_zero, .bit_select, .bit_from_base, .literal, .dest_present,
      .debug_enable, .debug_pair_select, .debug_clock_pin, .debug_data_pin_in,
      .debug_data_pin_out, .debug_data_pin_oe_n, .debug_data_out, .debug_data_drive,
      .debug_clock, .debug_data, .debug_pair_valid, .data_addr, .data_reserved, .pins_reserved);
   debug_tool u_tool (
      .sys_clk, .clk_drive, .clk_level, .dat_drive, .dat_level, .settled(tool_settled));
   // released lines are pulled up, so a wrongly steered pair reads high
   assign debug_clock_pin   = (clk_drive & clk_level) | ~clk_drive;
   assign debug_data_pin_in = (~debug_data_pin_oe_n & debug_data_pin_out)
                            | (debug_data_pin_oe_n & ~(dat_drive & ~dat_level));

   always #2.5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 5000) begin
         fails++;
         tally_and_finish();
      end
   end
   always @(posedge sys_clk) if (frame_on && tool_settled) begin
      chk(debug_clock, debug_clock_pin[frame_pair], "clock steering");
      chk(debug_data, debug_data_pin_in[frame_pair], "data steering");
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] want, input string msg);
      check_count++;
      if (seen !== want) begin
         fails++;
         $display("wrong value at %0t: %s, seen %0h expected %0h", $time, msg, seen, want);
      end
   endtask
   task automatic tally_and_finish;
      $display("comparisons %0d, mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic tick;
      if (fetch_ready !== 1'b1) stalls++;
      @(posedge sys_clk);
      #1;
      if (instr_done === 1'b1) dones++;
   endtask
   task automatic issue(input logic [23:0] w);
      fetch_word  = w;
      fetch_valid = 1'b1;
      for (int k = 0; k < 10 && fetch_ready !== 1'b1; k++) tick();
      tick();
   endtask
   task automatic check_fields(input logic [23:0] w, input logic [23:0] x);
      chk(opcode, w[23:16], "opcode");
      chk(is_two_word, w[23:16] inside {8'h02, 8'h04, 8'h08}, "two-word flag");
      case (w[23:16])
         8'hB4: begin
            chk(op_class, decode_pkg::CLS_FILE, "file class");
            chk(file_addr, w[12:0], "file address");
            chk(dest_is_reg_zero, !w[13], "file destination");
         end
         8'h40: begin
            chk(op_class, decode_pkg::CLS_REG3, "register class");
            chk(base_operand_reg, w[14:11], "base register");
            chk(source_operand_reg, w[3:0], "source register");
            chk(source_mode, w[6:4], "source mode");
            chk(dest_operand_reg, w[10:7], "dest register");
         end
         8'hA8, 8'hAD: begin
            chk(op_class, decode_pkg::CLS_BIT, "bit class");
            chk(bit_from_base, w[23:16] == 8'hAD, "bit source");
            if (w[23:16] == 8'hA8) chk(bit_select, w[15:12], "bit number");
         end
         8'hB0: begin
            chk(op_class, decode_pkg::CLS_LIT, "literal class");
            chk(literal, w[13:4], "literal");
            chk(dest_present, !w[14], "destination present");
         end
         8'h02, 8'h04, 8'h08: chk(extension, x[15:0], "extension");
         8'h00: chk(op_class, decode_pkg::CLS_NOP, "lone second word");
         default: ;
      endcase
   endtask
   task automatic run_row(input row_type r);
      int want;
      cond_true  = r.cond;
      skip_taken = r.skip;
      stalls     = 0;
      dones      = 0;
      issue(r.w0);
      if (r.n > 1) issue(r.w1);
      if (r.n > 2) issue(r.w2);
      fetch_valid = 1'b0;
      for (int k = 0; k < 12 && dones == 0; k++) tick();
      want = (r.cyc == 0) ? int'(cycle_count) : r.cyc;
      if (r.cyc == 0) chk(cycle_count inside {2'h2, 2'h3}, 1'b1, "long op cycles");
      else chk(cycle_count, want, "cycle count");
      chk(stalls, want - r.n, "refused cycles");
      chk(dones, 1, "retirements");
      if (!r.skip) check_fields(r.w0, r.w1);
      tick();
      chk(instr_done, 1'b0, "done pulse width");
   endtask

   initial begin
      repeat (2) @(posedge sys_clk);
      #1;
      rstn = 1'b1;
      chk(fetch_ready, 1'b1, "ready after reset");
      chk(debug_data_pin_oe_n, 3'h7, "pins released after reset");
      foreach (rows[i]) run_row(rows[i]);
      // reset in mid-stall must clear the stall and the results
      issue(24'h060000);
      fetch_valid = 1'b0;
      rstn        = 1'b0;
      tick();
      chk(fetch_ready, 1'b1, "ready in reset");
      chk(cycle_count, 2'h0, "count in reset");
      rstn = 1'b1;
      tick();
      chk(instr_done, 1'b0, "no retirement after reset");
      debug_enable = 1'b1;
      for (int s = 3; s >= 0; s--) begin
         debug_pair_select = 2'(s);
         en_exp = (s != 0) ? ~(3'h1 << (3 - s)) : 3'h7;
         repeat (4) tick();
         chk(debug_pair_valid, s != 0, "pair valid");
         if (s != 0) begin
            frame_pair = 3 - s;
            frame_on   = 1'b1;
            u_tool.frame(3 - s, 8'hA5 ^ 8'(s));
            frame_on   = 1'b0;
         end
         debug_data_drive = 1'b1;
         repeat (4) tick();
         chk(debug_data_pin_oe_n, en_exp, "drive enable");
         chk(debug_data_pin_in, en_exp, "driven low");
         debug_data_out = 1'b1;
         repeat (4) tick();
         if (s != 0) chk(debug_data, 1'b1, "driven high read back");
         debug_data_drive = 1'b0;
         debug_data_out   = 1'b0;
      end
      for (int e = 0; e < 2; e++) foreach (addrs[i]) begin
         debug_enable = e[0];
         data_addr    = addrs[i];
         repeat (3) tick();
         chk(data_reserved, e == 1 && addrs[i] < decode_pkg::DEBUG_RAM_BYTES, "data held");
         chk(pins_reserved, e[0], "pins held");
      end
      tally_and_finish();
   end
endmodule
